// [core/psp_ctrl.sv]
// Parallel slave port with control pin port and AHB-Lite registers.
// Assumes pins are asynchronous and the bus runs on ref_clk_in.
//
// Operation
// R1: Direction bits set each control pin's direction.
// R2: Slave mode uses control pins as strobes.
// R3: Host sets pins input and digital first.
// R4: Analog control pins read back as zero.
// R5: Direction bits drive outputs even when analog.
// R6: Power-on reset makes control pins analog.
// R7: Slave mode data port is external latch.
// R8: Chip select and write low captures byte.
// R9: Chip select and read low drives latch.
// R10: Read strobe low with select means read.
// R11: Write strobe low with select means write.
// R12: Chip select is active low.
// R13: Input full flag set on external write.
// R14: Output full flag until external read.
// R15: Overflow on write to full input latch.
// R16: Mode bit picks slave port or GPIO.
// R17: Status bit 3 always reads zero.
// R18: Internal write loads latch, read returns pins.
// R19: Internal read clears, write sets full flags.
// R20: Transfer end sets flag, enable requests irq.
// R21: Strobes synchronised before low detection.
`timescale 1ns/1ps

module psp_ctrl (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic [7:0]  data_pin_in,
    output logic      [7:0]  data_pin_out,
    output logic      [7:0]  data_pin_oe_out,
    input  wire logic [2:0]  ctrl_pin_in,
    output logic      [2:0]  ctrl_pin_out,
    output logic      [2:0]  ctrl_pin_oe_out,
    output logic             irq_out
);

    // Pin synchronisers.
    logic [7:0] dpin_s1_reg;
    logic [7:0] dpin_s2_reg;
    logic [2:0] cpin_s1_reg;
    logic [2:0] cpin_s2_reg;

    // Software visible state.
    logic [2:0] dir_reg;
    logic       mode_reg;
    logic       ibf_reg;
    logic       obf_reg;
    logic       ovf_reg;
    logic [7:0] flag_reg;
    logic [7:0] enab_reg;
    logic [7:0] ancfg_reg;
    logic [7:0] ddir_reg;
    logic [7:0] dlat_reg;
    logic [7:0] inlat_reg;
    logic [2:0] clat_reg;

    // Bus pipeline.
    logic        wr_pend_reg;
    logic [7:0]  wr_idx_reg;
    logic        rd_pend_reg;
    logic [7:0]  rd_idx_reg;
    logic [31:0] hrdata_reg;
    logic        hready_reg;

    // Pin drivers.
    logic [7:0] dout_reg;
    logic [7:0] doe_reg;
    logic [2:0] cout_reg;
    logic [2:0] coe_reg;
    logic       irq_reg;

    psp_pkg::psp_xfer_e xfer_reg;
    psp_pkg::psp_xfer_e xfer_next;

    logic       ibf_next;
    logic       obf_next;
    logic       ovf_next;
    logic [7:0] flag_next;
    logic [7:0] flag_wr;
    logic [7:0] rd_byte;
    logic [7:0] doe_next;

    // Bus decode.
    wire       addr_ok;
    wire       rd_take;
    wire       wr_take;
    wire [7:0] acc_idx;
    wire [7:0] wdat;
    wire       sw_wr_data;
    wire       sw_wr_ctrl;
    wire       sw_wr_flag;
    wire       sw_wr_ddir;
    wire       sw_wr_dirst;
    wire       sw_wr_enab;
    wire       sw_wr_ancfg;
    wire       sw_rd_data;

    assign addr_ok = hsel_in & htrans_in[psp_pkg::TRANS_ACT_BIT]
                   & hready_in;
    assign rd_take = addr_ok & ~hwrite_in;
    assign wr_take = addr_ok & hwrite_in;
    assign acc_idx = haddr_in[psp_pkg::ADDR_MSB:psp_pkg::ADDR_LSB];
    assign wdat    = hwdata_in[7:0];

    assign sw_wr_data  = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_DATA);
    assign sw_wr_ctrl  = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_CTRL);
    assign sw_wr_flag  = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_FLAG);
    assign sw_wr_ddir  = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_DDIR);
    assign sw_wr_dirst = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_DIRST);
    assign sw_wr_enab  = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_ENAB);
    assign sw_wr_ancfg = wr_pend_reg & (wr_idx_reg == psp_pkg::IDX_ANCFG);
    assign sw_rd_data  = rd_pend_reg & (rd_idx_reg == psp_pkg::IDX_DATA);

    // Control pin strobes and analog selection.
    wire       pins_digital;
    wire [2:0] ctrl_rd;
    wire       cs_act;
    wire       wr_act;
    wire       rd_act;
    wire       ext_wr_start;
    wire       ext_rd_start;
    wire       ext_end;

    assign pins_digital = (ancfg_reg[3:0] == psp_pkg::DIG_CODE_A)
                        | (ancfg_reg[3:0] == psp_pkg::DIG_CODE_B);

    // R4: analog pins read zero.
    assign ctrl_rd = pins_digital ? cpin_s2_reg : 3'h0;

    // R2 R3 R12: select is low, strobes used in slave mode.
    assign cs_act = mode_reg & ~cpin_s2_reg[2];
    // R11: write needs select.
    assign wr_act = cs_act & ~cpin_s2_reg[1];
    // R10: read needs select.
    assign rd_act = cs_act & ~cpin_s2_reg[0];

    // R8: first detection of write.
    assign ext_wr_start = (xfer_reg == psp_pkg::XF_IDLE) & wr_act;
    // R9: first detection of read.
    assign ext_rd_start = (xfer_reg == psp_pkg::XF_IDLE) & ~wr_act
                        & rd_act;
    // R20: transfer completes.
    assign ext_end = ((xfer_reg == psp_pkg::XF_WRITE) & ~wr_act)
                   | ((xfer_reg == psp_pkg::XF_READ) & ~rd_act);

    // Transfer tracker.
    always_comb begin
        xfer_next = xfer_reg;
        unique case (xfer_reg)
            psp_pkg::XF_IDLE: begin
                if (ext_wr_start) begin
                    xfer_next = psp_pkg::XF_WRITE;
                end else if (ext_rd_start) begin
                    xfer_next = psp_pkg::XF_READ;
                end
            end
            psp_pkg::XF_WRITE: begin
                if (!wr_act) begin
                    xfer_next = psp_pkg::XF_IDLE;
                end
            end
            psp_pkg::XF_READ: begin
                if (!rd_act) begin
                    xfer_next = psp_pkg::XF_IDLE;
                end
            end
            default: begin
                xfer_next = psp_pkg::XF_IDLE;
            end
        endcase
    end

    // Status flag next values; hardware set wins over clear.
    always_comb begin
        ibf_next = ibf_reg;
        // R19: internal read clears input full.
        if (sw_rd_data) begin
            ibf_next = 1'b0;
        end
        // R13: external write sets input full.
        if (ext_wr_start) begin
            ibf_next = 1'b1;
        end
    end

    always_comb begin
        obf_next = obf_reg;
        // R14: external read empties output.
        if (ext_rd_start) begin
            obf_next = 1'b0;
        end
        // R19: internal write fills output in slave mode.
        if (sw_wr_data && mode_reg) begin
            obf_next = 1'b1;
        end
    end

    always_comb begin
        ovf_next = ovf_reg;
        if (sw_wr_dirst) begin
            ovf_next = wdat[psp_pkg::OVF_BIT];
        end
        // R15: overflow sticks until software.
        if (ext_wr_start && ibf_reg) begin
            ovf_next = 1'b1;
        end
    end

    assign flag_wr = sw_wr_flag ? wdat : flag_reg;

    always_comb begin
        flag_next = flag_wr;
        // R20: end of transfer sets flag.
        if (ext_end) begin
            flag_next[psp_pkg::IRQ_BIT] = 1'b1;
        end
    end

    // Register read mux.
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_idx_reg)
            psp_pkg::IDX_DATA: begin
                // R18: pins in GPIO mode, latch in slave mode.
                rd_byte = mode_reg ? inlat_reg : dpin_s2_reg;
            end
            psp_pkg::IDX_CTRL: begin
                rd_byte = {5'h00, ctrl_rd};
            end
            psp_pkg::IDX_FLAG: begin
                rd_byte = flag_reg;
            end
            psp_pkg::IDX_DDIR: begin
                rd_byte = ddir_reg;
            end
            psp_pkg::IDX_DIRST: begin
                // R17: bit 3 reads zero.
                rd_byte = {ibf_reg, obf_reg, ovf_reg, mode_reg,
                           1'b0, dir_reg};
            end
            psp_pkg::IDX_ENAB: begin
                rd_byte = enab_reg;
            end
            psp_pkg::IDX_ANCFG: begin
                rd_byte = ancfg_reg;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Data pin enables per bit.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_doe
            // R9 R16: drive on read in slave mode, else direction.
            assign doe_next[gi] = mode_reg
                ? ((xfer_reg == psp_pkg::XF_READ) & rd_act)
                : ~ddir_reg[gi];
        end
    endgenerate

    // R21: two-stage pin synchronisers.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dpin_s1_reg <= 8'h00;
            dpin_s2_reg <= 8'h00;
            cpin_s1_reg <= 3'h7;
            cpin_s2_reg <= 3'h7;
        end else begin
            dpin_s1_reg <= data_pin_in;
            dpin_s2_reg <= dpin_s1_reg;
            cpin_s1_reg <= ctrl_pin_in;
            cpin_s2_reg <= cpin_s1_reg;
        end
    end

    // Bus pipeline; reads take one wait state.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
            rd_pend_reg <= 1'b0;
            rd_idx_reg  <= 8'h00;
            hready_reg  <= 1'b1;
        end else begin
            wr_pend_reg <= wr_take;
            rd_pend_reg <= rd_take;
            hready_reg  <= ~rd_take;
            if (addr_ok) begin
                wr_idx_reg <= acc_idx;
                rd_idx_reg <= acc_idx;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Direction, mode and config registers.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // R6: reset leaves control pins analog inputs.
            dir_reg   <= psp_pkg::DIRST_RST[2:0];
            mode_reg  <= psp_pkg::DIRST_RST[psp_pkg::MODE_BIT];
            ancfg_reg <= psp_pkg::ANCFG_RST;
            ddir_reg  <= psp_pkg::DDIR_RST;
            enab_reg  <= psp_pkg::ENAB_RST;
        end else begin
            if (sw_wr_dirst) begin
                // R1 R16: direction bits and mode select.
                dir_reg  <= wdat[2:0];
                mode_reg <= wdat[psp_pkg::MODE_BIT];
            end
            if (sw_wr_ancfg) begin
                ancfg_reg <= wdat & psp_pkg::ANCFG_WMASK;
            end
            if (sw_wr_ddir) begin
                ddir_reg <= wdat;
            end
            if (sw_wr_enab) begin
                enab_reg <= wdat;
            end
        end
    end

    // Status flags and transfer state.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ibf_reg  <= psp_pkg::DIRST_RST[psp_pkg::IBF_BIT];
            obf_reg  <= psp_pkg::DIRST_RST[psp_pkg::OBF_BIT];
            ovf_reg  <= psp_pkg::DIRST_RST[psp_pkg::OVF_BIT];
            flag_reg <= psp_pkg::FLAG_RST;
            xfer_reg <= psp_pkg::XF_IDLE;
        end else begin
            ibf_reg  <= ibf_next;
            obf_reg  <= obf_next;
            ovf_reg  <= ovf_next;
            flag_reg <= flag_next;
            xfer_reg <= xfer_next;
        end
    end

    // Data latches.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dlat_reg  <= 8'h00;
            inlat_reg <= 8'h00;
            clat_reg  <= 3'h0;
        end else begin
            // R7 R18: internal write loads the output latch.
            if (sw_wr_data) begin
                dlat_reg <= wdat;
            end
            // R8: capture external byte.
            if (ext_wr_start) begin
                inlat_reg <= dpin_s2_reg;
            end
            if (sw_wr_ctrl) begin
                clat_reg <= wdat[2:0];
            end
        end
    end

    // Pin and interrupt drivers.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dout_reg <= 8'h00;
            doe_reg  <= 8'h00;
            cout_reg <= 3'h0;
            coe_reg  <= 3'h0;
            irq_reg  <= 1'b0;
        end else begin
            dout_reg <= dlat_reg;
            doe_reg  <= doe_next;
            cout_reg <= clat_reg;
            // R1 R5: direction drives outputs even when analog.
            coe_reg  <= ~dir_reg;
            // R20: request when flag and enable set.
            irq_reg  <= flag_reg[psp_pkg::IRQ_BIT]
                      & enab_reg[psp_pkg::IRQ_BIT];
        end
    end

    assign hrdata_out      = hrdata_reg;
    assign hreadyout_out   = hready_reg;
    assign hresp_out       = 1'b0;
    assign data_pin_out    = dout_reg;
    assign data_pin_oe_out = doe_reg;
    assign ctrl_pin_out    = cout_reg;
    assign ctrl_pin_oe_out = coe_reg;
    assign irq_out         = irq_reg;

endmodule : psp_ctrl

// [pkg/psp_pkg.sv]
// Constants and types for the parallel slave port block.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
package psp_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_DATA  = 8'h08;
    localparam logic [7:0] IDX_CTRL  = 8'h09;
    localparam logic [7:0] IDX_FLAG  = 8'h0C;
    localparam logic [7:0] IDX_DDIR  = 8'h88;
    localparam logic [7:0] IDX_DIRST = 8'h89;
    localparam logic [7:0] IDX_ENAB  = 8'h8C;
    localparam logic [7:0] IDX_ANCFG = 8'h9F;

    // Word index position inside the byte address.
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 9;
    localparam int TRANS_ACT_BIT = 1;

    // Fields of direction_and_slave_status.
    localparam int IBF_BIT  = 7;
    localparam int OBF_BIT  = 6;
    localparam int OVF_BIT  = 5;
    localparam int MODE_BIT = 4;

    // Slave port flag and enable position.
    localparam int IRQ_BIT = 7;

    // Reset values.
    localparam logic [7:0] DIRST_RST = 8'h07;
    localparam logic [7:0] FLAG_RST  = 8'h00;
    localparam logic [7:0] ENAB_RST  = 8'h00;
    localparam logic [7:0] ANCFG_RST = 8'h00;
    localparam logic [7:0] DDIR_RST  = 8'hFF;

    // Writable bits of analog_pin_config.
    localparam logic [7:0] ANCFG_WMASK = 8'h8F;

    // Analog config codes that make the control pins digital.
    localparam logic [3:0] DIG_CODE_A = 4'h6;
    localparam logic [3:0] DIG_CODE_B = 4'h7;

    // External transfer tracker.
    typedef enum logic [2:0] {
        XF_IDLE  = 3'b001,
        XF_WRITE = 3'b010,
        XF_READ  = 3'b100
    } psp_xfer_e;

endpackage : psp_pkg

// [bench/psp_ctrl_assertions.sv]
// Concurrent checks on the bus and pin ports of the slave port block.
// Assumes hready_in is tied to hreadyout_out by the bench.
`timescale 1ns/1ps

module psp_ctrl_chk (
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        hsel_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic [7:0]  data_pin_oe_out,
    input wire logic [2:0]  ctrl_pin_in,
    input wire logic [2:0]  ctrl_pin_oe_out,
    input wire logic        irq_out
);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
    assign wr_take = hsel_in & htrans_in[1] & hready_in & hwrite_in;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    hresp_okay_a: assert property (
        hresp_out == 1'b0) else $error("hresp not okay");
    read_wait_a: assert property (
        rd_take |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait wrong");
    write_nowait_a: assert property (
        wr_take |=> hreadyout_out) else $error("write stalled");
    rdata_upper_a: assert property (
        hrdata_out[31:8] == 24'h0) else $error("upper read bits set");
    rdata_hold_a: assert property (
        $changed(hrdata_out) |-> $past(rd_take, 2))
        else $error("read data moved alone");
    ctrl_dir_a: assert property (
        $changed(ctrl_pin_oe_out) |-> $past(wr_take, 3))
        else $error("control drive moved alone");
    read_drive_a: assert property (
        $rose(data_pin_oe_out[0]) && !$past(wr_take, 2)
        && !$past(wr_take, 3) |-> !ctrl_pin_in[2] && !ctrl_pin_in[0])
        else $error("data driven unselected");
    read_release_a: assert property (
        $fell(data_pin_oe_out[0]) && !$past(wr_take, 2)
        && !$past(wr_take, 3) |-> ctrl_pin_in[2] || ctrl_pin_in[0])
        else $error("data released early");
    cover property (rd_take);
    cover property (wr_take);
    cover property ($rose(irq_out));
    cover property ($rose(data_pin_oe_out[0]));
endmodule : psp_ctrl_chk

bind psp_ctrl psp_ctrl_chk psp_ctrl_chk_inst (
    .ref_clk_in, .rst_n_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
    .hrdata_out, .hreadyout_out, .hresp_out, .data_pin_oe_out,
    .ctrl_pin_in, .ctrl_pin_oe_out, .irq_out
);

// [bench/psp_host_model.sv]
// Behavioural external processor on the slave port pins.
// Assumes each cycle is started just after a rising clock edge.
`timescale 1ns/1ps

module psp_host_model (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] dev_data_in,
    input  wire logic [7:0] dev_oe_in,
    output logic      [2:0] ctrl_out,
    output logic      [7:0] bus_out
);
    logic [7:0] host_data;
    logic       host_drive;
    // An undriven bus shows the inverse of the host's last data byte.
    assign bus_out = (dev_oe_in & dev_data_in)
        | (~dev_oe_in & (host_drive ? host_data : ~host_data));
    initial begin
        ctrl_out   = 3'b111;
        host_data  = 8'h00;
        host_drive = 1'b0;
    end
    task automatic ext_cycle(input logic [2:0] pins, input logic drive,
                             input logic [7:0] b, input int hold,
                             output logic [7:0] got);
        @(posedge ref_clk_in);
        host_data  <= b;
        host_drive <= drive;
        ctrl_out   <= pins;
        repeat (hold) @(posedge ref_clk_in);
        got = bus_out;
        ctrl_out <= 3'b111;
        @(posedge ref_clk_in);
        host_drive <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
    endtask : ext_cycle
endmodule : psp_host_model

// [bench/test_psp_ctrl.sv]
// Self-checking bench for the parallel slave port block.
// Assumes the processor model drives the port pins.
`timescale 1ns/1ps

module test_psp_ctrl;
    typedef struct packed {
        logic       wr;
        logic [7:0] widx;
        logic [7:0] wd;
        logic [7:0] ridx;
        logic [7:0] ex;
    } psp_row_s;
    logic        ref_clk_in;
    logic        rst_n_in;
    logic        hsel_in;
    logic [31:0] haddr_in;
    logic [1:0]  htrans_in;
    logic        hwrite_in;
    logic [2:0]  hsize_in;
    logic        hready_in;
    logic [31:0] hwdata_in;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic [7:0]  data_pin_in;
    logic [7:0]  data_pin_out;
    logic [7:0]  data_pin_oe_out;
    logic [2:0]  ctrl_pin_in;
    logic [2:0]  ctrl_pin_out;
    logic [2:0]  ctrl_pin_oe_out;
    logic        irq_out;
    logic [2:0]  host_ctrl;
    logic [7:0]  rd;
    int          fail_count;
    int          check_count;
    psp_row_s    rows [16] = '{
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_DIRST, 8'h07},
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_FLAG, 8'h00},
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_ENAB, 8'h00},
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_ANCFG, 8'h00},
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_CTRL, 8'h00},
        {1'b0, 8'h00, 8'h00, psp_pkg::IDX_DDIR, 8'hFF},
        {1'b1, 8'h01, 8'hFF, 8'h01, 8'h00},
        {1'b1, psp_pkg::IDX_DIRST, 8'hEA, psp_pkg::IDX_DIRST, 8'h22},
        {1'b1, psp_pkg::IDX_DIRST, 8'h07, psp_pkg::IDX_DIRST, 8'h07},
        {1'b1, psp_pkg::IDX_ANCFG, 8'hFF, psp_pkg::IDX_ANCFG, 8'h8F},
        {1'b1, psp_pkg::IDX_ANCFG, 8'h06, psp_pkg::IDX_CTRL, 8'h07},
        {1'b1, psp_pkg::IDX_DDIR, 8'h00, psp_pkg::IDX_DDIR, 8'h00},
        {1'b1, psp_pkg::IDX_DATA, 8'h5A, psp_pkg::IDX_ENAB, 8'h00},
        {1'b1, psp_pkg::IDX_ENAB, 8'h80, psp_pkg::IDX_DATA, 8'h5A},
        {1'b1, psp_pkg::IDX_DDIR, 8'hFF, psp_pkg::IDX_ENAB, 8'h80},
        {1'b1, psp_pkg::IDX_ANCFG, 8'h00, psp_pkg::IDX_CTRL, 8'h00}
    };
    assign hsize_in    = 3'b010;
    assign hready_in   = hreadyout_out;
    assign ctrl_pin_in = (ctrl_pin_oe_out & ctrl_pin_out)
        | (~ctrl_pin_oe_out & host_ctrl);
    psp_ctrl psp_ctrl_inst (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .hsel_in         (hsel_in),
        .haddr_in        (haddr_in),
        .htrans_in       (htrans_in),
        .hwrite_in       (hwrite_in),
        .hsize_in        (hsize_in),
        .hready_in       (hready_in),
        .hwdata_in       (hwdata_in),
        .hrdata_out      (hrdata_out),
        .hreadyout_out   (hreadyout_out),
        .hresp_out       (hresp_out),
        .data_pin_in     (data_pin_in),
        .data_pin_out    (data_pin_out),
        .data_pin_oe_out (data_pin_oe_out),
        .ctrl_pin_in     (ctrl_pin_in),
        .ctrl_pin_out    (ctrl_pin_out),
        .ctrl_pin_oe_out (ctrl_pin_oe_out),
        .irq_out         (irq_out)
    );
    psp_host_model psp_host_model_inst (
        .ref_clk_in  (ref_clk_in),
        .dev_data_in (data_pin_out),
        .dev_oe_in   (data_pin_oe_out),
        .ctrl_out    (host_ctrl),
        .bus_out     (data_pin_in)
    );
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    task automatic check8(input string name, input logic [7:0] ex,
                          input logic [7:0] got);
        check_count++;
        if (got !== ex) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, ex, got);
        end
    endtask : check8
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        hsel_in   <= 1'b1;
        haddr_in  <= {22'h0, idx, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        do @(posedge ref_clk_in); while (hready_in !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= {24'h0, wd};
        do @(posedge ref_clk_in); while (hready_in !== 1'b1);
        rd = hrdata_out[7:0];
    endtask : bus
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00);
        check8($sformatf("reg %h", idx), ex, rd);
    endtask : rd_chk
    task automatic ext(input logic [2:0] pins, input logic drive,
                       input logic [7:0] b, input int hold);
        psp_host_model_inst.ext_cycle(pins, drive, b, hold, rd);
    endtask : ext
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end
    initial begin
        fail_count  = 0;
        check_count = 0;
        rst_n_in    = 1'b0;
        hsel_in     = 1'b0;
        haddr_in    = 32'h0;
        htrans_in   = 2'b00;
        hwrite_in   = 1'b0;
        hwdata_in   = 32'h0;
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        check8("ctrl_oe", 8'h00, {5'h0, ctrl_pin_oe_out});
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus(1'b1, rows[i].widx, rows[i].wd);
            end
            rd_chk(rows[i].ridx, rows[i].ex);
        end
        bus(1'b1, psp_pkg::IDX_CTRL, 8'h05);
        bus(1'b1, psp_pkg::IDX_DIRST, 8'h02);
        repeat (2) @(posedge ref_clk_in);
        check8("ctrl_oe", 8'h05, {5'h0, ctrl_pin_oe_out});
        check8("ctrl_out", 8'h05, {5'h0, ctrl_pin_out});
        bus(1'b1, psp_pkg::IDX_DIRST, 8'h07);
        bus(1'b1, psp_pkg::IDX_ANCFG, 8'h06);
        bus(1'b1, psp_pkg::IDX_DIRST, 8'h17);
        ext(3'b001, 1'b1, 8'h3C, 4);
        rd_chk(psp_pkg::IDX_DIRST, 8'h97);
        rd_chk(psp_pkg::IDX_FLAG, 8'h80);
        check8("irq", 8'h01, {7'h0, irq_out});
        rd_chk(psp_pkg::IDX_DATA, 8'h3C);
        ext(3'b101, 1'b1, 8'h44, 8);
        rd_chk(psp_pkg::IDX_DIRST, 8'h17);
        ext(3'b001, 1'b1, 8'h5D, 8);
        ext(3'b001, 1'b1, 8'h6E, 4);
        rd_chk(psp_pkg::IDX_DIRST, 8'hB7);
        bus(1'b0, psp_pkg::IDX_DATA, 8'h00);
        rd_chk(psp_pkg::IDX_DIRST, 8'h37);
        bus(1'b1, psp_pkg::IDX_FLAG, 8'h00);
        bus(1'b1, psp_pkg::IDX_DATA, 8'hA5);
        rd_chk(psp_pkg::IDX_DIRST, 8'h77);
        check8("irq", 8'h00, {7'h0, irq_out});
        ext(3'b010, 1'b0, 8'h00, 8);
        check8("ext_read", 8'hA5, rd);
        rd_chk(psp_pkg::IDX_DIRST, 8'h37);
        rd_chk(psp_pkg::IDX_FLAG, 8'h80);
        bus(1'b1, psp_pkg::IDX_DIRST, 8'h07);
        bus(1'b1, psp_pkg::IDX_FLAG, 8'h00);
        ext(3'b001, 1'b1, 8'h11, 8);
        rd_chk(psp_pkg::IDX_DIRST, 8'h07);
        rd_chk(psp_pkg::IDX_FLAG, 8'h00);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_chk(psp_pkg::IDX_DIRST, 8'h07);
        rd_chk(psp_pkg::IDX_ANCFG, 8'h00);
        finish_test();
    end
endmodule : test_psp_ctrl
